/* File: core/hsp_device.sv */
// Device end of the host serial port: frame decoder, function 0 registers, buffer bursts
// Operation
// - Command 8, address 24, optional length 16
// - Register cycles hit function 0 or core
// - Register write: 16 data bits, error byte
// - Burst select bit set means burst
// - Bursts reach only the packet buffers
// - Byte length up to 64K; zero moves nothing
// - Length field when enabled; cleared at reset
// - Without length, deselect ends the burst
// - Burst read: padding, error byte, data
// - Prefetch ahead, address advances internally
// - Failed access raises the shared interrupt
// - Sixteen-bit registers move in one command
// - Every register cycle has a fixed clock count
// - Burst data is one continuous stream
// - While asleep only function 0 answers
// - Port runs from the host clock only
// - Sleep register permits sleep, starts wake-up
// - Function 0 works with core powered off
// - Core power loss needs full re-initialisation
// - Port stays selected until pin reset
// - Only pin or power-on reset clears
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_device import hsp_pkg::*; (
    hsp_if.device link, // Serial link, its sclk clocks this end
    input wire logic rst, // Pin or power-on reset, synchronous to sclk
    input wire logic core_powered, // Core supply present, asynchronous
    input wire logic core_awake, // Core out of deep sleep, asynchronous
    output logic [23:0] reg_addr, // Core register address
    output logic [15:0] reg_wdata, // Core register write data
    output logic reg_we, // Core register write strobe
    output logic reg_re, // Core register read strobe
    input wire logic [15:0] reg_rdata, // Core register data, edge after reg_re
    output logic [23:0] buf_addr, // Packet buffer byte address
    output logic [7:0] buf_wdata, // Packet buffer write byte
    output logic buf_we, // Packet buffer write strobe
    output logic buf_re, // Packet buffer read strobe
    input wire logic [7:0] buf_rdata, // Packet buffer byte, edge after buf_re
    output logic sleep_allow, // Deep sleep permitted
    output logic wake_req, // Wake-up requested
    output logic port_active // Serial mode taken until reset
);
    hsp_dev_state_t state_q;
    logic [1:0] pwr_sync_q;
    logic [1:0] awake_sync_q;
    logic pwr_prev_q;
    logic awake_prev_q;
    logic [15:0] ctrl_q;
    logic [15:0] sleep_q;
    logic fail_q;
    logic wake_done_q;
    logic lost_q;
    logic active_q;
    logic [5:0] bit_q;
    logic [31:0] sh_q;
    logic [7:0] cmd_q;
    logic [23:0] addr_q;
    logic [15:0] len_q;
    logic [15:0] tx_q;
    logic [3:0] pad_left_q;
    logic err_q;
    logic [7:0] pf_q;
    logic [15:0] rd_q;
    logic pf_cap_q;
    logic rd_cap_q;
    logic [31:0] rx_next;
    logic core_ready;
    logic is_burst;
    logic is_write;
    logic with_len;
    logic [23:0] hdr_addr;
    logic hdr_done;
    logic hdr_fail;
    logic byte_end;
    logic addr_f0;
    logic f0_we;
    logic [15:0] f0_rdata;
    logic [7:0] err_byte;

    assign rx_next = {sh_q[30:0], link.mosi};
    assign core_ready = pwr_sync_q[1] & awake_sync_q[1];
    assign is_burst = cmd_q[`HSP_BURST_BIT];
    assign is_write = cmd_q[`HSP_WRITE_BIT];
    assign with_len = is_burst & ctrl_q[`HSP_CTRL_LEN_EN];
    assign hdr_addr = with_len ? addr_q : rx_next[23:0];
    assign hdr_done = (state_q == DS_HDR) && (bit_q == (with_len ? 6'h2F : 6'h1F));
    // Function 0 always answers; everything else needs a running core
    assign hdr_fail = !core_ready && (is_burst || hdr_addr[23:16] != `HSP_F0_SPACE);
    assign byte_end = bit_q[2:0] == 3'h7;
    assign addr_f0 = addr_q[23:16] == `HSP_F0_SPACE;
    assign f0_we = (state_q == DS_WDATA) && (bit_q == 6'h0F) && addr_f0;
    assign err_byte = err_q ? `HSP_ERR_FAIL : `HSP_ERR_OK;
    assign link.miso = tx_q[15] & !link.host_port_select_n;
    assign link.miso_oe = !link.host_port_select_n;
    assign link.host_port_irq = fail_q | wake_done_q;
    assign sleep_allow = sleep_q[`HSP_SLEEP_ALLOW];
    assign wake_req = sleep_q[`HSP_SLEEP_WAKE];
    assign port_active = active_q;

    always_comb begin
        case (addr_q)
            `HSP_F0_CTRL: f0_rdata = ctrl_q;
            `HSP_F0_SLEEP: f0_rdata = sleep_q;
            `HSP_F0_STATUS: f0_rdata = {12'h000, core_ready, lost_q, wake_done_q, fail_q};
            default: f0_rdata = 16'h0000;
        endcase
    end

    // Core status crossing into the link clock; sclk is the only clock here
    always_ff @(posedge link.sclk) begin
        if (rst) begin
            pwr_sync_q <= 2'h0;
            // Awake assumed at reset, so no false wake edge follows it
            awake_sync_q <= 2'h3;
            pwr_prev_q <= 1'b0;
            awake_prev_q <= 1'b1;
        end else begin
            pwr_sync_q <= {pwr_sync_q[0], core_powered};
            awake_sync_q <= {awake_sync_q[0], core_awake};
            pwr_prev_q <= pwr_sync_q[1];
            awake_prev_q <= awake_sync_q[1];
        end
    end

    // Function 0 registers survive everything but the pin or power-on reset
    always_ff @(posedge link.sclk) begin
        if (rst) begin
            ctrl_q <= `HSP_CTRL_RESET;
            sleep_q <= `HSP_SLEEP_RESET;
            fail_q <= 1'b0;
            wake_done_q <= 1'b0;
            lost_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            if (hdr_done) begin
                active_q <= 1'b1;
            end
            if (f0_we && addr_q == `HSP_F0_CTRL) begin
                ctrl_q <= rx_next[15:0];
            end
            if (f0_we && addr_q == `HSP_F0_SLEEP) begin
                sleep_q <= rx_next[15:0];
            end else if (awake_sync_q[1] && !awake_prev_q) begin
                sleep_q[`HSP_SLEEP_WAKE] <= 1'b0;
            end
            // Write one clears; a new event in the same cycle wins
            if (hdr_done && hdr_fail) begin
                fail_q <= 1'b1;
            end else if (f0_we && addr_q == `HSP_F0_STATUS && rx_next[`HSP_ST_FAIL]) begin
                fail_q <= 1'b0;
            end
            if (awake_sync_q[1] && !awake_prev_q) begin
                wake_done_q <= 1'b1;
            end else if (f0_we && addr_q == `HSP_F0_STATUS && rx_next[`HSP_ST_WAKE]) begin
                wake_done_q <= 1'b0;
            end
            if (!pwr_sync_q[1] && pwr_prev_q) begin
                lost_q <= 1'b1;
            end else if (f0_we && addr_q == `HSP_F0_STATUS && rx_next[`HSP_ST_LOST]) begin
                lost_q <= 1'b0;
            end
        end
    end

    // Frame logic; deselect clears it at the next sclk rise, so a last strobe still lands
    always_ff @(posedge link.sclk) begin
        if (link.host_port_select_n) begin
            state_q <= DS_HDR;
            bit_q <= 6'h00;
            sh_q <= 32'h0;
            cmd_q <= 8'h00;
            addr_q <= 24'h0;
            len_q <= 16'h0000;
            tx_q <= 16'h0000;
            pad_left_q <= 4'h0;
            err_q <= 1'b0;
            pf_q <= 8'h00;
            rd_q <= 16'h0000;
            pf_cap_q <= 1'b0;
            rd_cap_q <= 1'b0;
            reg_addr <= 24'h0;
            reg_wdata <= 16'h0000;
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            buf_addr <= 24'h0;
            buf_wdata <= 8'h00;
            buf_we <= 1'b0;
            buf_re <= 1'b0;
        end else begin
            sh_q <= rx_next;
            tx_q <= {tx_q[14:0], 1'b0};
            bit_q <= bit_q + 6'h01;
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            buf_we <= 1'b0;
            buf_re <= 1'b0;
            pf_cap_q <= buf_re;
            rd_cap_q <= reg_re;
            if (pf_cap_q) begin
                pf_q <= buf_rdata;
            end
            if (rd_cap_q) begin
                rd_q <= reg_rdata;
            end
            case (state_q)
                DS_HDR: begin
                    if (bit_q == 6'h07) begin
                        cmd_q <= rx_next[7:0];
                    end
                    if (bit_q == 6'h1F) begin
                        addr_q <= rx_next[23:0];
                    end
                    if (bit_q == 6'h2F) begin
                        len_q <= rx_next[15:0];
                    end
                    if (hdr_done) begin
                        bit_q <= 6'h00;
                        err_q <= hdr_fail;
                        addr_q <= hdr_addr;
                        reg_addr <= hdr_addr;
                        buf_addr <= hdr_addr;
                        if (!is_burst && is_write) begin
                            state_q <= DS_WDATA;
                        end else if (!is_burst) begin
                            reg_re <= !hdr_fail && hdr_addr[23:16] != `HSP_F0_SPACE;
                            tx_q <= {(hdr_fail ? `HSP_ERR_FAIL : `HSP_ERR_OK), 8'h00};
                            state_q <= DS_ERR;
                        end else if (is_write) begin
                            tx_q <= {(hdr_fail ? `HSP_ERR_FAIL : `HSP_ERR_OK), 8'h00};
                            state_q <= DS_ERR;
                        end else begin
                            buf_re <= !hdr_fail;
                            addr_q <= hdr_addr + 24'h1;
                            if (ctrl_q[`HSP_CTRL_PAD_LO+:4] != 4'h0) begin
                                pad_left_q <= ctrl_q[`HSP_CTRL_PAD_LO+:4];
                                state_q <= DS_PAD;
                            end else begin
                                tx_q <= {(hdr_fail ? `HSP_ERR_FAIL : `HSP_ERR_OK), 8'h00};
                                state_q <= DS_ERR;
                            end
                        end
                    end
                end
                DS_WDATA: begin
                    if (bit_q == 6'h0F) begin
                        bit_q <= 6'h00;
                        reg_wdata <= rx_next[15:0];
                        reg_we <= !err_q && !addr_f0;
                        tx_q <= {err_byte, 8'h00};
                        state_q <= DS_ERR;
                    end
                end
                DS_PAD: begin
                    if (byte_end) begin
                        bit_q <= 6'h00;
                        pad_left_q <= pad_left_q - 4'h1;
                        if (pad_left_q == 4'h1) begin
                            tx_q <= {err_byte, 8'h00};
                            state_q <= DS_ERR;
                        end
                    end
                end
                DS_ERR: begin
                    if (byte_end) begin
                        bit_q <= 6'h00;
                        if (!is_burst && !is_write) begin
                            tx_q <= addr_f0 ? f0_rdata : (err_q ? 16'h0000 : rd_q);
                            state_q <= DS_RDATA;
                        end else if (!is_burst || err_q || (with_len && len_q == 16'h0000)) begin
                            state_q <= DS_END;
                        end else if (is_write) begin
                            state_q <= DS_BWR;
                        end else begin
                            tx_q <= {pf_q, 8'h00};
                            buf_addr <= addr_q;
                            addr_q <= addr_q + 24'h1;
                            buf_re <= 1'b1;
                            len_q <= len_q - 16'h0001;
                            state_q <= DS_BRD;
                        end
                    end
                end
                DS_RDATA: begin
                    if (bit_q == 6'h0F) begin
                        state_q <= DS_END;
                    end
                end
                DS_BWR: begin
                    if (byte_end) begin
                        bit_q <= 6'h00;
                        buf_wdata <= rx_next[7:0];
                        buf_addr <= addr_q;
                        addr_q <= addr_q + 24'h1;
                        buf_we <= 1'b1;
                        len_q <= len_q - 16'h0001;
                        if (with_len && len_q == 16'h0001) begin
                            state_q <= DS_END;
                        end
                    end
                end
                DS_BRD: begin
                    if (byte_end) begin
                        bit_q <= 6'h00;
                        if (with_len && len_q == 16'h0000) begin
                            state_q <= DS_END;
                        end else begin
                            tx_q <= {pf_q, 8'h00};
                            buf_addr <= addr_q;
                            addr_q <= addr_q + 24'h1;
                            buf_re <= 1'b1;
                            len_q <= len_q - 16'h0001;
                        end
                    end
                end
                DS_END: begin
                    bit_q <= 6'h00;
                end
                default: begin
                    state_q <= DS_END;
                end
            endcase
        end
    end
endmodule : hsp_device

/* File: core/hsp_defines.svh */
// Shared constants of the host serial port: field sizes, addresses, bit positions, codes
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH
`define HSP_BURST_BIT 7
`define HSP_WRITE_BIT 6
`define HSP_F0_SPACE 8'h00
`define HSP_F0_CTRL 24'h000000
`define HSP_F0_SLEEP 24'h000001
`define HSP_F0_STATUS 24'h000002
`define HSP_CTRL_LEN_EN 0
`define HSP_CTRL_PAD_LO 8
`define HSP_CTRL_RESET 16'h0000
`define HSP_SLEEP_ALLOW 0
`define HSP_SLEEP_WAKE 1
`define HSP_SLEEP_RESET 16'h0000
`define HSP_ST_FAIL 0
`define HSP_ST_WAKE 1
`define HSP_ST_LOST 2
`define HSP_ERR_OK 8'h00
`define HSP_ERR_FAIL 8'h01
`define HSP_HDR_BITS 20'h00020
`define HSP_HDR_LEN_BITS 20'h00030
`define HSP_SCLK_HALF 4'h4
`endif

/* File: core/hsp_pkg.sv */
// Types shared by both ends of the host serial port
package hsp_pkg;
    typedef enum logic [2:0] {
        DS_HDR, DS_WDATA, DS_PAD, DS_ERR, DS_RDATA, DS_BWR, DS_BRD, DS_END
    } hsp_dev_state_t;
    typedef enum logic {
        HS_IDLE, HS_RUN
    } hsp_host_state_t;
endpackage : hsp_pkg

/* File: core/hsp_if.sv */
// Serial link between the host and the device end
`timescale 1ns/1ps
interface hsp_if;
    logic sclk;
    logic host_port_select_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic host_port_irq;
    wire miso_line;
    assign miso_line = miso_oe ? miso : 1'b1; // Released line rests at its pull-up
    modport device (input sclk, input host_port_select_n, input mosi,
        output miso, output miso_oe, output host_port_irq);
    modport host (output sclk, output host_port_select_n, output mosi,
        input miso_line, input host_port_irq);
endinterface : hsp_if

/* File: core/hsp_host.sv */
// Host end of the host serial port: clock divider and frame sequencer
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_host import hsp_pkg::*; (
    hsp_if.host link, // Serial link, this end makes sclk
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic cmd_valid, // Transfer request
    output logic cmd_ready, // Request taken this cycle
    input wire logic cmd_burst, // Burst cycle, else register cycle
    input wire logic cmd_write, // Write, else read
    input wire logic [23:0] cmd_addr, // Target address
    input wire logic cmd_use_len, // Device has the length field enabled
    input wire logic [15:0] cmd_len, // Burst byte count
    input wire logic [15:0] cmd_nbytes, // Byte count clocked when no length field
    input wire logic [3:0] cmd_pad, // Device padding setting
    input wire logic [15:0] cmd_wdata, // Register write data
    input wire logic [7:0] wr_data, // Next burst write byte
    output logic wr_take, // Burst write byte taken
    output logic [7:0] rd_data, // Burst read byte
    output logic rd_valid, // Burst read byte valid
    output logic [7:0] rsp_err, // Error byte of the last transfer
    output logic [15:0] rsp_rdata, // Register read data
    output logic rsp_done, // Transfer finished
    output logic irq // Synchronised device interrupt
);
    hsp_host_state_t state_q;
    logic [3:0] half_q;
    logic sclk_q;
    logic sel_n_q;
    logic mosi_q;
    logic [1:0] miso_sync_q;
    logic [1:0] irq_sync_q;
    logic [19:0] slot_q;
    logic [19:0] err_q;
    logic [19:0] data_q;
    logic [19:0] end_q;
    logic [47:0] tx_q;
    logic [7:0] bw_q;
    logic [15:0] rx_q;
    logic [2:0] bb_q;
    logic burst_q;
    logic write_q;
    logic fall;
    logic [19:0] hdr_n;
    logic [19:0] nb;
    logic [19:0] err_n;
    logic [19:0] in_data;

    assign fall = (half_q == `HSP_SCLK_HALF - 4'h1) && sclk_q;
    assign cmd_ready = (state_q == HS_IDLE) && fall;
    assign hdr_n = (cmd_burst && cmd_use_len) ? `HSP_HDR_LEN_BITS : `HSP_HDR_BITS;
    assign nb = {4'h0, cmd_use_len ? cmd_len : cmd_nbytes};
    assign err_n = !cmd_burst ? (cmd_write ? hdr_n + 20'h10 : hdr_n)
        : (cmd_write ? hdr_n : hdr_n + {13'h0, cmd_pad, 3'h0});
    assign in_data = slot_q - data_q;
    assign link.sclk = sclk_q;
    assign link.host_port_select_n = sel_n_q;
    assign link.mosi = mosi_q;
    assign irq = irq_sync_q[1];

    always_ff @(posedge clk) begin
        if (rst) begin
            half_q <= 4'h0;
            sclk_q <= 1'b0;
            miso_sync_q <= 2'h0;
            irq_sync_q <= 2'h0;
        end else begin
            half_q <= (half_q == `HSP_SCLK_HALF - 4'h1) ? 4'h0 : half_q + 4'h1;
            if (half_q == `HSP_SCLK_HALF - 4'h1) begin
                sclk_q <= ~sclk_q;
            end
            miso_sync_q <= {miso_sync_q[0], link.miso_line};
            irq_sync_q <= {irq_sync_q[0], link.host_port_irq};
        end
    end

    // Drive and sample happen together at each falling edge of sclk
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= HS_IDLE;
            sel_n_q <= 1'b1;
            mosi_q <= 1'b0;
            slot_q <= 20'h0;
            err_q <= 20'h0;
            data_q <= 20'h0;
            end_q <= 20'h0;
            tx_q <= 48'h0;
            bw_q <= 8'h00;
            rx_q <= 16'h0000;
            bb_q <= 3'h0;
            burst_q <= 1'b0;
            write_q <= 1'b0;
            wr_take <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            rsp_err <= 8'h00;
            rsp_rdata <= 16'h0000;
            rsp_done <= 1'b0;
        end else begin
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            rsp_done <= 1'b0;
            case (state_q)
                HS_IDLE: begin
                    if (cmd_valid && fall) begin
                        sel_n_q <= 1'b0;
                        mosi_q <= cmd_burst;
                        tx_q <= {cmd_write, 6'h00, cmd_addr,
                            (cmd_burst && cmd_use_len) ? cmd_len : cmd_wdata, 1'b0};
                        burst_q <= cmd_burst;
                        write_q <= cmd_write;
                        slot_q <= 20'h1;
                        bb_q <= 3'h0;
                        err_q <= err_n;
                        data_q <= (!cmd_burst && cmd_write) ? hdr_n : err_n + 20'h8;
                        end_q <= !cmd_burst ? hdr_n + 20'h18
                            : err_n + 20'h8 + {1'b0, nb[15:0], 3'h0};
                        state_q <= HS_RUN;
                    end
                end
                HS_RUN: begin
                    if (fall) begin
                        slot_q <= slot_q + 20'h1;
                        rx_q <= {rx_q[14:0], miso_sync_q[1]};
                        if (slot_q == end_q) begin
                            sel_n_q <= 1'b1;
                            rsp_done <= 1'b1;
                            state_q <= HS_IDLE;
                        end else if (burst_q && write_q && slot_q >= data_q) begin
                            bb_q <= bb_q + 3'h1;
                            if (bb_q == 3'h0) begin
                                mosi_q <= wr_data[7];
                                bw_q <= {wr_data[6:0], 1'b0};
                                wr_take <= 1'b1;
                            end else begin
                                mosi_q <= bw_q[7];
                                bw_q <= {bw_q[6:0], 1'b0};
                            end
                        end else begin
                            mosi_q <= tx_q[47];
                            tx_q <= {tx_q[46:0], 1'b0};
                        end
                        if (slot_q == err_q + 20'h7) begin
                            rsp_err <= {rx_q[6:0], miso_sync_q[1]};
                        end
                        if (!burst_q && !write_q && slot_q == end_q - 20'h1) begin
                            rsp_rdata <= {rx_q[14:0], miso_sync_q[1]};
                        end
                        if (burst_q && !write_q && slot_q >= data_q && in_data[2:0] == 3'h7) begin
                            rd_data <= {rx_q[6:0], miso_sync_q[1]};
                            rd_valid <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= HS_IDLE;
                end
            endcase
        end
    end
endmodule : hsp_host

/* File: tb/hsp_link_asserts.sv */
// Checks on the serial link between host and device ends
`timescale 1ns/1ps
module hsp_link_asserts (
    input wire logic sclk, // Link clock
    input wire logic rst, // Device reset
    input wire logic host_port_select_n, // Frame select
    input wire logic mosi, // Host data
    input wire logic miso, // Device data
    input wire logic miso_oe, // Device output enable
    input wire logic host_port_irq // Device interrupt
);
    logic [6:0] cnt_q;
    logic [7:0] cmd_q;
    wire frm = !host_port_select_n;
    // Slot number within the frame, and the command byte
    always_ff @(posedge sclk) begin
        if (rst || !frm) cnt_q <= 7'h00;
        else if (cnt_q != 7'h7F) cnt_q <= cnt_q + 7'h01;
    end
    always_ff @(posedge sclk) begin
        if (rst) cmd_q <= 8'h00;
        else if (frm && cnt_q < 7'h08) cmd_q <= {cmd_q[6:0], mosi};
    end
    default clocking cb @(posedge sclk); endclocking
    default disable iff (rst);
    oe_select_a: assert property (miso_oe == frm) else $error("miso enable off select");
    idle_low_a: assert property (!frm |-> !miso) else $error("miso set while idle");
    hdr_quiet_a: assert property (frm && cnt_q < 7'h20 |-> !miso)
        else $error("miso set in header");
    wdata_quiet_a: assert property (frm && cmd_q[7:6] == 2'b01
        && cnt_q inside {[7'h20:7'h36]} |-> !miso) else $error("write answer misplaced");
    rerr_high_a: assert property (frm && cmd_q[7:6] == 2'b00
        && cnt_q inside {[7'h20:7'h26]} |-> !miso) else $error("read error byte wrong");
    reg_span_a: assert property (frm && !cmd_q[7] && cnt_q > 7'h07 |-> cnt_q < 7'h38)
        else $error("register frame too long");
    reg_end_a: assert property ($rose(host_port_select_n) && !cmd_q[7] |-> cnt_q == 7'h38)
        else $error("register frame length wrong");
    fail_irq_a: assert property (frm && miso && (cmd_q[7:6] == 2'b00 && cnt_q == 7'h27
        || cmd_q[7:6] == 2'b01 && cnt_q == 7'h37) |-> ##[1:3] host_port_irq)
        else $error("no interrupt after failure");
endmodule : hsp_link_asserts

/* File: tb/tb_top.sv */
// Bench: host and device ends joined by the serial link
`timescale 1ns/1ps
`include "hsp_defines.svh"
module tb_top;
    logic clk = 1'b0, rst = 1'b1, dev_rst = 1'b1, pwr = 1'b1, valid = 1'b0, bst = 1'b0;
    logic wr = 1'b0, use_len = 1'b0, ready, take, rdv, done, irq, we, bwe, sa, act, wq, awk = 1'b1;
    logic [3:0] pad = 4'h0;
    logic [7:0] wrd = 8'h00, rdd, err, bwd, lw;
    logic [15:0] len = 16'h0000, wd = 16'h0000, rrd = 16'h0000, rdat, rwd, v, sv_d;
    logic [23:0] ad = 24'h000000, rad, bad, sv_a, ra;
    int seed = 14, fails = 0, n_compared = 0, nwr, i, k;
    logic [7:0] rq[$];
    hsp_if link();
    hsp_host hsp_host_inst (.link(link), .clk(clk), .rst(rst), .cmd_valid(valid),
        .cmd_ready(ready), .cmd_burst(bst), .cmd_write(wr), .cmd_addr(ad), .cmd_use_len(use_len),
        .cmd_len(len), .cmd_nbytes(len), .cmd_pad(pad), .cmd_wdata(wd), .wr_data(wrd),
        .wr_take(take), .rd_data(rdd), .rd_valid(rdv), .rsp_err(err), .rsp_rdata(rdat),
        .rsp_done(done), .irq(irq));
    hsp_device hsp_device_inst (.link(link), .rst(dev_rst), .core_powered(pwr),
        .core_awake(awk), .reg_addr(rad), .reg_wdata(rwd), .reg_we(we), .reg_re(),
        .reg_rdata(rrd), .buf_addr(bad), .buf_wdata(bwd), .buf_we(bwe), .buf_re(),
        .buf_rdata(bad[7:0] ^ 8'h5A), .sleep_allow(sa), .wake_req(wq), .port_active(act));
    hsp_link_asserts hsp_link_asserts_inst (.sclk(link.sclk), .rst(dev_rst), .mosi(link.mosi),
        .host_port_select_n(link.host_port_select_n), .miso(link.miso),
        .miso_oe(link.miso_oe), .host_port_irq(link.host_port_irq));
    always #50 clk = ~clk;
    always @(negedge clk) if (take) wrd <= wrd + 8'h01;
    always @(posedge clk) if (rdv) rq.push_back(rdd);
    always @(posedge link.sclk) begin
        if (we) {sv_a, sv_d} <= {rad, rwd};
        if (bwe) chk("wr addr b", bad, ra + 24'(nwr));
        if (bwe && nwr > 0) chk("wr byte", bwd, lw + 8'h01);
        if (bwe) lw <= bwd;
        if (bwe) nwr <= nwr + 1;
    end
    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic [1:0] bw, input logic [23:0] a, input logic [15:0] n, d);
        {bst, wr, ad, len, wd} = {bw, a, n, d};
        valid = 1'b1;
        rq.delete();
        nwr = 0;
        #1;
        while (ready !== 1'b1) begin
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        valid = 1'b0;
        while (done !== 1'b1) @(posedge clk);
        @(posedge link.sclk);
        @(negedge clk);
    endtask : xfer
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (30) @(negedge clk);
        dev_rst = 1'b0;
        xfer(2'b00, `HSP_F0_CTRL, 16'h0000, 16'h0000);
        chk("ctrl reset", rdat, `HSP_CTRL_RESET);
        v = 16'($random(seed));
        xfer(2'b01, `HSP_F0_CTRL, 16'h0000, v);
        {pad, use_len} = {v[11:8], v[0]};
        xfer(2'b00, `HSP_F0_CTRL, 16'h0000, 16'h0000);
        chk("ctrl", rdat, v);
        for (i = 0; i < 4; i++) begin
            ra = {8'h20, 16'($random(seed))};
            v = 16'($random(seed));
            xfer(2'b01, ra, 16'h0000, v);
            chk("wr addr", sv_a, ra);
            chk("wr data", sv_d, v);
            rrd = 16'($random(seed));
            xfer(2'b00, ra, 16'h0000, 16'h0000);
            chk("rd data", rdat, rrd);
            chk("rd err", err, `HSP_ERR_OK);
            xfer(2'b10, ra, 16'(i * 3), 16'h0000);
            chk("burst n", 24'(rq.size()), 24'(i * 3));
            for (k = 0; k < rq.size(); k++) chk("byte", rq[k], 8'(ra + k) ^ 8'h5A);
            xfer(2'b11, ra, 16'(i * 2), 16'h0000);
            chk("burst wr n", 24'(nwr), 24'(i * 2));
        end
        pwr = 1'b0;
        repeat (20) @(negedge clk);
        xfer(2'b00, 24'h200000, 16'h0000, 16'h0000);
        chk("off err", err, `HSP_ERR_FAIL);
        xfer(2'b11, 24'h000010, 16'h0002, 16'h0000);
        chk("off burst", 24'(nwr), 24'h000000);
        xfer(2'b01, `HSP_F0_SLEEP, 16'h0000, 16'h0001);
        chk("fn0 off", err, `HSP_ERR_OK);
        chk("sleep", sa, 1'b1);
        chk("irq set", irq, 1'b1);
        xfer(2'b01, `HSP_F0_STATUS, 16'h0000, 16'h0007);
        repeat (10) @(negedge clk);
        chk("irq clear", irq, 1'b0);
        xfer(2'b01, `HSP_F0_SLEEP, 16'h0000, 16'h0003);
        chk("wake req", wq, 1'b1);
        awk = 1'b0;
        repeat (30) @(negedge clk);
        awk = 1'b1;
        repeat (40) @(negedge clk);
        chk("wake done", {wq, irq}, 2'b01);
        chk("mode", act, 1'b1);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : tb_top
